// ==== common/hrs_cfg.svh ====
// addresses, field positions, reset values and sizes of the sensor register block
`ifndef HRS_CFG_SVH
`define HRS_CFG_SVH
// register addresses
`define HRS_A_STATUS1 8'h00
`define HRS_A_IRQ_EN1 8'h02
`define HRS_A_WR_IDX 8'h04
`define HRS_A_LOST 8'h05
`define HRS_A_RD_IDX 8'h06
`define HRS_A_READOUT 8'h07
`define HRS_A_BUF_SETUP 8'h08
`define HRS_A_SLOT_LO 8'h09
`define HRS_A_SLOT_HI 8'h0A
`define HRS_A_SYS_CTRL 8'h0D
`define HRS_A_SAMP_ONE 8'h0E
`define HRS_A_SAMP_TWO 8'h0F
`define HRS_A_PROX_THR 8'h10
`define HRS_A_EM_ONE 8'h11
`define HRS_A_EM_THREE 8'h13
`define HRS_A_EM_RANGE 8'h14
`define HRS_A_EM_PROX 8'h15
`define HRS_A_IDENTITY 8'hFF
// positions in the five-flag vector
`define HRS_F_NEAR_FULL 4
`define HRS_F_NEW_SAMPLE 3
`define HRS_F_AMBIENT 2
`define HRS_F_PROX 1
`define HRS_F_SUPPLY 0
// enable bits, stored as byte bits 7:4
`define HRS_EN_HI 7
`define HRS_EN_LO 4
`define HRS_E_PROX 0
// buffer_setup fields
`define HRS_B_CLR_ON_READ 6
`define HRS_B_OVERWRITE 4
`define HRS_B_THR_HI 3
`define HRS_B_THR_LO 0
// system_ctrl bits
`define HRS_B_BUF_EN 2
`define HRS_B_PWR_DOWN 1
`define HRS_B_SOFT_RST 0
// reset values and writable masks
`define HRS_RST_BYTE 8'h00
`define HRS_RST_BUF_SETUP 8'h0F
`define HRS_RST_EN 4'h0
`define HRS_RST_IDX 5'h00
`define HRS_RST_FILL 6'h00
`define HRS_RST_PHASE 2'h0
`define HRS_M_BUF_SETUP 8'h7F
`define HRS_M_SAMP_TWO 8'h07
// buffer geometry
`define HRS_IDX_W 5
`define HRS_SAMPLE_W 24
`define HRS_DEPTH 6'h20
`define HRS_LOST_MAX 5'h1F
`define HRS_LAST_BYTE 2'h2
`endif

// ==== common/hrs_pkg.sv ====
// types shared by the sensor register block
package hrs_pkg;
`include "hrs_cfg.svh"
    // measurement mode, one-hot
    typedef enum logic [2:0] {
        HRS_IDLE = 3'h1,
        HRS_PROX = 3'h2,
        HRS_RATE = 3'h4
    } hrs_mode_t;
    typedef logic [`HRS_SAMPLE_W-1:0] hrs_sample_t;
    typedef logic [`HRS_IDX_W-1:0] hrs_idx_t;
endpackage

// ==== common/hrs_mem_if.sv ====
// carrier between the register block and its sample memory
interface hrs_mem_if;
    import hrs_pkg::*;
    logic wr_en;
    hrs_idx_t wr_addr;
    hrs_sample_t wr_data;
    hrs_idx_t rd_addr;
    hrs_sample_t rd_data;
    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// ==== core/hrs_sample_mem.sv ====
// sample memory with registered read data
`include "hrs_cfg.svh"
module hrs_sample_mem
    import hrs_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // memory port
    hrs_mem_if.store bus
);
    hrs_sample_t cells [0:`HRS_DEPTH-1];

    // write port, no reset on the array
    always_ff @(posedge ref_clk) begin
        if (bus.wr_en) begin
            cells[bus.wr_addr] <= bus.wr_data;
        end
    end

    // read data follows the read address one cycle later
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus.rd_data <= '0;
        end else begin
            bus.rd_data <= cells[bus.rd_addr];
        end
    end
endmodule // hrs_sample_mem

// ==== core/hrs_regmap.sv ====
// register map, event flags and sample buffer control of the sensor
`include "hrs_cfg.svh"
// What this block does
// [R1] set near-full when free space reaches threshold
// [R2] readout read clears near-full if option set
// [R3] status read clears near-full and proximity flags
// [R4] heart-rate mode stored sample sets new-sample
// [R5] status or readout read clears new-sample
// [R6] heart-rate mode ambient cancel limit sets overflow flag
// [R7] status read clears ambient overflow flag
// [R8] proximity count above threshold sets proximity flag
// [R9] proximity masked: start straight into sampling
// [R10] undervoltage sets supply-low flag
// [R11] soft reset never sets supply-low
// [R12] status read clears supply-low flag
// [R13] four 4-bit slot sources in two registers
// [R14] flags other than supply-low reach interrupt only when enabled
// [R15] write index advances once per stored sample
// [R16] lost samples counted, saturating at 0x1F
// [R17] interrupt pin pulled low while enabled flag
module hrs_regmap
    import hrs_pkg::*;
#(
    parameter logic [7:0] IDENTITY_CODE = 8'h5A // arbitrary value
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // front end events
    input wire logic sample_valid,
    input wire logic [`HRS_SAMPLE_W-1:0] sample_data,
    input wire logic [7:0] proximity_count,
    input wire logic ambient_limit,
    input wire logic undervoltage_lockout,
    // controls toward the front end
    output logic [15:0] slot_sources,
    output logic power_down,
    output logic proximity_active,
    output logic heart_rate_active,
    output logic [7:0] emitter_drive,
    // open-drain interrupt pin
    output logic interrupt_out_n_o,
    output logic interrupt_out_n_oe
);
    hrs_mode_t mode, next_mode;
    logic [4:0] flag, flag_set, flag_clr;
    logic [3:0] irq_en;
    logic [7:0] buffer_setup, slot_select_low, slot_select_high, system_ctrl;
    logic [7:0] sampling_setup_one, sampling_setup_two, proximity_threshold;
    logic [7:0] emitter_one_amplitude, emitter_three_amplitude, emitter_current_range;
    logic [7:0] proximity_emitter_amplitude, next_rdata;
    hrs_idx_t buffer_write_index, buffer_read_index, next_wr_idx, next_rd_idx;
    logic [5:0] fill, next_fill;
    logic [4:0] lost_sample_count;
    logic [1:0] byte_phase;
    logic ambient_prev, start_pend, slots_on;
    logic rd_status, rd_readout, soft_rst, wr_wr_idx, wr_rd_idx, ptr_wr;
    logic push, full, pop, store, roll, lost_ev, near_ev, prox_cross, ambient_ev;

    hrs_mem_if mem_bus ();

    hrs_sample_mem u_mem (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .bus(mem_bus.store)
    );

    // access decode
    assign rd_status = reg_rd && (reg_addr == `HRS_A_STATUS1);
    assign rd_readout = reg_rd && (reg_addr == `HRS_A_READOUT);
    assign soft_rst = reg_wr && (reg_addr == `HRS_A_SYS_CTRL) && reg_wdata[`HRS_B_SOFT_RST];
    assign wr_wr_idx = reg_wr && (reg_addr == `HRS_A_WR_IDX) && !soft_rst;
    assign wr_rd_idx = reg_wr && (reg_addr == `HRS_A_RD_IDX) && !soft_rst;
    assign ptr_wr = wr_wr_idx || wr_rd_idx;

    // configuration registers, soft reset restores defaults
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_en <= `HRS_RST_EN;
            buffer_setup <= `HRS_RST_BUF_SETUP;
            slot_select_low <= `HRS_RST_BYTE;
            slot_select_high <= `HRS_RST_BYTE;
            system_ctrl <= `HRS_RST_BYTE;
            sampling_setup_one <= `HRS_RST_BYTE;
            sampling_setup_two <= `HRS_RST_BYTE;
            proximity_threshold <= `HRS_RST_BYTE;
            emitter_one_amplitude <= `HRS_RST_BYTE;
            emitter_three_amplitude <= `HRS_RST_BYTE;
            emitter_current_range <= `HRS_RST_BYTE;
            proximity_emitter_amplitude <= `HRS_RST_BYTE;
        end else if (soft_rst) begin
            irq_en <= `HRS_RST_EN;
            buffer_setup <= `HRS_RST_BUF_SETUP;
            slot_select_low <= `HRS_RST_BYTE;
            slot_select_high <= `HRS_RST_BYTE;
            system_ctrl <= `HRS_RST_BYTE;
            sampling_setup_one <= `HRS_RST_BYTE;
            sampling_setup_two <= `HRS_RST_BYTE;
            proximity_threshold <= `HRS_RST_BYTE;
            emitter_one_amplitude <= `HRS_RST_BYTE;
            emitter_three_amplitude <= `HRS_RST_BYTE;
            emitter_current_range <= `HRS_RST_BYTE;
            proximity_emitter_amplitude <= `HRS_RST_BYTE;
        end else if (reg_wr) begin
            case (reg_addr)
                `HRS_A_IRQ_EN1: irq_en <= reg_wdata[`HRS_EN_HI:`HRS_EN_LO];
                `HRS_A_BUF_SETUP: buffer_setup <= reg_wdata & `HRS_M_BUF_SETUP;
                `HRS_A_SLOT_LO: slot_select_low <= reg_wdata; // [R13]
                `HRS_A_SLOT_HI: slot_select_high <= reg_wdata; // [R13]
                `HRS_A_SYS_CTRL: system_ctrl <= reg_wdata & ~(`HRS_RST_BYTE | 8'h01);
                `HRS_A_SAMP_ONE: sampling_setup_one <= reg_wdata;
                `HRS_A_SAMP_TWO: sampling_setup_two <= reg_wdata & `HRS_M_SAMP_TWO;
                `HRS_A_PROX_THR: proximity_threshold <= reg_wdata;
                `HRS_A_EM_ONE: emitter_one_amplitude <= reg_wdata;
                `HRS_A_EM_THREE: emitter_three_amplitude <= reg_wdata;
                `HRS_A_EM_RANGE: emitter_current_range <= reg_wdata;
                `HRS_A_EM_PROX: proximity_emitter_amplitude <= reg_wdata;
                default: ;
            endcase
        end
    end

    // slot one in low nibble of the low register through slot four in high nibble of the high one
    assign slot_sources = {slot_select_high, slot_select_low}; // [R13]
    assign power_down = system_ctrl[`HRS_B_PWR_DOWN];
    assign slots_on = (slot_sources != 16'h0000);

    // a slot write starts a measurement two cycles later
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_pend <= 1'b0;
        end else begin
            start_pend <= reg_wr && !soft_rst && ((reg_addr == `HRS_A_SLOT_LO) || (reg_addr == `HRS_A_SLOT_HI));
        end
    end

    // mode sequencing
    assign prox_cross = (mode == HRS_PROX) && sample_valid && (proximity_count > proximity_threshold); // [R8]
    always_comb begin
        next_mode = mode;
        case (mode)
            HRS_IDLE: next_mode = HRS_IDLE;
            HRS_PROX: if (prox_cross) begin
                next_mode = HRS_RATE; // [R8]
            end
            HRS_RATE: next_mode = HRS_RATE;
            default: next_mode = HRS_IDLE;
        endcase
        if (start_pend && slots_on) begin
            next_mode = irq_en[`HRS_E_PROX] ? HRS_PROX : HRS_RATE; // [R9]
        end
        if (soft_rst || power_down || !slots_on) begin
            next_mode = HRS_IDLE;
        end
    end

    // mode register and the mode-dependent outputs
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= HRS_IDLE;
            proximity_active <= 1'b0;
            heart_rate_active <= 1'b0;
            emitter_drive <= `HRS_RST_BYTE;
        end else begin
            mode <= next_mode;
            proximity_active <= (next_mode == HRS_PROX);
            heart_rate_active <= (next_mode == HRS_RATE);
            emitter_drive <= (next_mode == HRS_PROX) ? proximity_emitter_amplitude : emitter_one_amplitude;
        end
    end

    // buffer traffic; a pop makes room for a push in the same cycle
    assign push = (mode == HRS_RATE) && sample_valid && system_ctrl[`HRS_B_BUF_EN] && !ptr_wr && !soft_rst;
    assign full = (fill == `HRS_DEPTH);
    assign pop = rd_readout && (byte_phase == `HRS_LAST_BYTE) && (fill != `HRS_RST_FILL) && !ptr_wr;
    assign store = push && (!full || pop || buffer_setup[`HRS_B_OVERWRITE]);
    assign roll = push && full && !pop && buffer_setup[`HRS_B_OVERWRITE];
    assign lost_ev = push && full && !pop;
    assign next_wr_idx = buffer_write_index + {4'h0, store}; // [R15]
    assign next_rd_idx = buffer_read_index + {4'h0, pop} + {4'h0, roll};
    assign next_fill = fill + {5'h00, store && !roll} - {5'h00, pop};
    assign near_ev = store && !roll && (next_fill == (`HRS_DEPTH - {2'h0, buffer_setup[`HRS_B_THR_HI:`HRS_B_THR_LO]})); // [R1]

    // memory hookup
    assign mem_bus.wr_en = store;
    assign mem_bus.wr_addr = buffer_write_index;
    assign mem_bus.wr_data = sample_data;
    assign mem_bus.rd_addr = buffer_read_index;

    // indices and fill level; host writes to an index resync the fill
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            buffer_write_index <= `HRS_RST_IDX;
            buffer_read_index <= `HRS_RST_IDX;
            fill <= `HRS_RST_FILL;
        end else if (soft_rst) begin
            buffer_write_index <= `HRS_RST_IDX;
            buffer_read_index <= `HRS_RST_IDX;
            fill <= `HRS_RST_FILL;
        end else if (wr_wr_idx) begin
            buffer_write_index <= reg_wdata[`HRS_IDX_W-1:0];
            fill <= {1'b0, 5'(reg_wdata[`HRS_IDX_W-1:0] - buffer_read_index)};
        end else if (wr_rd_idx) begin
            buffer_read_index <= reg_wdata[`HRS_IDX_W-1:0];
            fill <= {1'b0, 5'(buffer_write_index - reg_wdata[`HRS_IDX_W-1:0])};
        end else begin
            buffer_write_index <= next_wr_idx; // [R15]
            buffer_read_index <= next_rd_idx;
            fill <= next_fill;
        end
    end

    // lost sample counter, saturating
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lost_sample_count <= `HRS_RST_IDX;
        end else if (soft_rst || wr_rd_idx) begin
            lost_sample_count <= `HRS_RST_IDX;
        end else if (lost_ev && (lost_sample_count != `HRS_LOST_MAX)) begin
            lost_sample_count <= lost_sample_count + 5'h01; // [R16]
        end
    end

    // byte position within a three-byte sample
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            byte_phase <= `HRS_RST_PHASE;
        end else if (soft_rst || ptr_wr) begin
            byte_phase <= `HRS_RST_PHASE;
        end else if (rd_readout) begin
            byte_phase <= (byte_phase == `HRS_LAST_BYTE) ? `HRS_RST_PHASE : byte_phase + 2'h1;
        end
    end

    // ambient edge detect
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ambient_prev <= 1'b0;
        end else begin
            ambient_prev <= ambient_limit;
        end
    end
    assign ambient_ev = (mode == HRS_RATE) && ambient_limit && !ambient_prev; // [R6]

    // flag set and clear terms
    assign flag_set[`HRS_F_NEAR_FULL] = near_ev; // [R1]
    assign flag_set[`HRS_F_NEW_SAMPLE] = store; // [R4]
    assign flag_set[`HRS_F_AMBIENT] = ambient_ev; // [R6]
    assign flag_set[`HRS_F_PROX] = prox_cross; // [R8]
    assign flag_set[`HRS_F_SUPPLY] = undervoltage_lockout; // [R10] [R11]
    assign flag_clr[`HRS_F_NEAR_FULL] = rd_status || soft_rst || (rd_readout && buffer_setup[`HRS_B_CLR_ON_READ]); // [R2] [R3]
    assign flag_clr[`HRS_F_NEW_SAMPLE] = rd_status || rd_readout || soft_rst; // [R5]
    assign flag_clr[`HRS_F_AMBIENT] = rd_status || soft_rst; // [R7]
    assign flag_clr[`HRS_F_PROX] = rd_status || soft_rst; // [R3]
    assign flag_clr[`HRS_F_SUPPLY] = rd_status; // [R12]

    // sticky flags, a set wins over a clear in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_flag
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    flag[gi] <= 1'b0;
                end else if (flag_set[gi]) begin
                    flag[gi] <= 1'b1;
                end else if (flag_clr[gi]) begin
                    flag[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // read data mux
    always_comb begin
        case (reg_addr)
            `HRS_A_STATUS1: next_rdata = {flag[4:1], 3'h0, flag[`HRS_F_SUPPLY]};
            `HRS_A_IRQ_EN1: next_rdata = {irq_en, 4'h0};
            `HRS_A_WR_IDX: next_rdata = {3'h0, buffer_write_index};
            `HRS_A_LOST: next_rdata = {3'h0, lost_sample_count};
            `HRS_A_RD_IDX: next_rdata = {3'h0, buffer_read_index};
            `HRS_A_READOUT: case (byte_phase)
                2'h0: next_rdata = mem_bus.rd_data[23:16];
                2'h1: next_rdata = mem_bus.rd_data[15:8];
                default: next_rdata = mem_bus.rd_data[7:0];
            endcase
            `HRS_A_BUF_SETUP: next_rdata = buffer_setup;
            `HRS_A_SLOT_LO: next_rdata = slot_select_low;
            `HRS_A_SLOT_HI: next_rdata = slot_select_high;
            `HRS_A_SYS_CTRL: next_rdata = system_ctrl;
            `HRS_A_SAMP_ONE: next_rdata = sampling_setup_one;
            `HRS_A_SAMP_TWO: next_rdata = sampling_setup_two;
            `HRS_A_PROX_THR: next_rdata = proximity_threshold;
            `HRS_A_EM_ONE: next_rdata = emitter_one_amplitude;
            `HRS_A_EM_THREE: next_rdata = emitter_three_amplitude;
            `HRS_A_EM_RANGE: next_rdata = emitter_current_range;
            `HRS_A_EM_PROX: next_rdata = proximity_emitter_amplitude;
            `HRS_A_IDENTITY: next_rdata = IDENTITY_CODE;
            default: next_rdata = `HRS_RST_BYTE;
        endcase
    end

    // read answer one cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `HRS_RST_BYTE;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : reg_rdata;
            reg_rvalid <= reg_rd;
        end
    end

    // open-drain interrupt, supply-low has no enable and always reaches the pin
    assign interrupt_out_n_o = 1'b0;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_out_n_oe <= 1'b0;
        end else begin
            interrupt_out_n_oe <= (|(flag[4:1] & irq_en)) || flag[`HRS_F_SUPPLY]; // [R14] [R17]
        end
    end

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence prox_hit_s;
        (mode == HRS_PROX) && sample_valid && (proximity_count > proximity_threshold) && !soft_rst && !start_pend
            && !power_down && slots_on;
    endsequence
    sequence status_read_s;
        rd_status && !near_ev && !prox_cross;
    endsequence

    near_full_set_a: assert property (store && !roll && !pop && !ptr_wr && // [R1]
        (fill + 6'h01 == `HRS_DEPTH - {2'h0, buffer_setup[3:0]}) |=> flag[4])
        else $error("near-full flag missed its threshold");
    data_read_clear_a: assert property (rd_readout && !near_ev && !soft_rst |=> flag[4] == ($past(flag[4]) && !$past(buffer_setup[6]))) // [R2]
        else $error("readout read handled near-full wrongly");
    status_read_clear_a: assert property (status_read_s |=> !flag[4] && !flag[1]) // [R3]
        else $error("status read left near-full or proximity set");
    new_sample_a: assert property ((mode == HRS_RATE) && sample_valid && system_ctrl[2] && !full && !ptr_wr && !soft_rst |=> flag[3] && (buffer_write_index == $past(buffer_write_index) + 5'h01)) // [R4]
        else $error("stored sample did not set flag or advance index");
    new_sample_clear_a: assert property ((rd_status || rd_readout) && !store |=> !flag[3]) // [R5]
        else $error("new-sample flag survived a read");
    ambient_set_a: assert property (ambient_ev |=> flag[2]) else $error("ambient overflow flag not set"); // [R6]
    ambient_clear_a: assert property (rd_status && !ambient_ev |=> !flag[2]) else $error("ambient flag kept"); // [R7]
    prox_hit_a: assert property (prox_hit_s |=> flag[1] && (mode == HRS_RATE)) // [R8]
        else $error("proximity crossing not taken");
    prox_skip_a: assert property (start_pend && slots_on && !power_down && !soft_rst && !irq_en[0] |=> mode == HRS_RATE) // [R9]
        else $error("masked proximity did not start sampling");
    supply_soft_a: assert property (soft_rst && !undervoltage_lockout && !flag[0] |=> !flag[0]) // [R11]
        else $error("soft reset raised supply-low");
    supply_set_a: assert property (undervoltage_lockout |=> flag[0]) else $error("supply-low flag not set"); // [R10]
    supply_clear_a: assert property (rd_status && !undervoltage_lockout |=> !flag[0]) // [R12]
        else $error("supply-low flag survived a status read");
    lost_saturate_a: assert property ((lost_sample_count == 5'h1F) && !soft_rst && !wr_rd_idx |=> lost_sample_count == 5'h1F) // [R16]
        else $error("lost count wrapped");
    irq_pin_a: assert property (##1 interrupt_out_n_oe == $past((|(flag[4:1] & irq_en)) || flag[0])) // [R17]
        else $error("interrupt pin does not follow enabled flags");
endmodule // hrs_regmap

// ==== verification/hrs_front_model.sv ====
// behavioural front end that hands the sensor one sample per request
module hrs_front_model
    import hrs_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // request from the bench
    input wire logic req,
    input wire logic [23:0] req_data,
    input wire logic [7:0] req_count,
    // toward the sensor
    output logic sample_valid,
    output logic [23:0] sample_data,
    output logic [7:0] proximity_count
);
    timeunit 1ns;
    timeprecision 1ps;
    // quiet lines at time zero
    initial begin
        sample_valid = 1'b0;
        sample_data = 24'h000000;
        proximity_count = 8'h00;
    end
    // one pulse per request; data scrambled outside it so stale words never pass
    always @(posedge ref_clk) begin
        sample_valid <= req;
        sample_data <= req ? req_data : ~sample_data;
        proximity_count <= req ? req_count : ~proximity_count;
    end
endmodule // hrs_front_model

// ==== verification/tb_hrs_regmap.sv ====
// self-checking bench of the sensor register block
module tb_hrs_regmap
    import hrs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] ID = 8'h3C; // arbitrary value
    logic ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, amb = 0, uvl = 0, req = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, cnt = 8'h00, rdata, thr, x, pc, emit, rv;
    logic [7:0] ra [6] = '{8'h09, 8'h0A, 8'h0E, 8'h0F, 8'h13, 8'h14};
    logic [23:0] rdat = 24'h000000, sdata, d;
    logic [15:0] slots;
    logic rvalid, sv, pd, pa, ha, io, oe;
    logic [31:0] seed = 32'h0001096B;
    int n_fail = 0, checked = 0, cyc = 0;
    // clock and design under test
    always #20 ref_clk = ~ref_clk;
    hrs_regmap #(.IDENTITY_CODE(ID)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .reg_rvalid(rvalid),
        .sample_valid(sv), .sample_data(sdata), .proximity_count(pc), .ambient_limit(amb),
        .undervoltage_lockout(uvl), .slot_sources(slots), .power_down(pd), .proximity_active(pa),
        .heart_rate_active(ha), .emitter_drive(emit), .interrupt_out_n_o(io), .interrupt_out_n_oe(oe));
    hrs_front_model fe (.ref_clk(ref_clk), .req(req), .req_data(rdat), .req_count(cnt),
        .sample_valid(sv), .sample_data(sdata), .proximity_count(pc));
    // xorshift source and expectation of the near-full pin
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic near(int i, logic [3:0] t);
        return i >= 32 - t;
    endfunction
    // verdict and compare
    task automatic end_sim();
        if (n_fail == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // byte strobe port and front end drivers
    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(posedge ref_clk) #1;
        {reg_addr, reg_wdata, reg_wr} = {a, v, 1'b1};
        @(posedge ref_clk) #1;
        reg_wr = 0;
    endtask
    task automatic rd(logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk) #1;
        {reg_addr, reg_rd} = {a, 1'b1};
        @(posedge ref_clk) #1;
        reg_rd = 0;
        chk("read valid", 1, rvalid);
        v = rdata;
    endtask
    task automatic rc(logic [7:0] a, logic [7:0] e);
        rd(a, x);
        chk($sformatf("register %h", a), e, x);
    endtask
    task automatic push(logic [23:0] v, logic [7:0] c);
        @(posedge ref_clk) #1;
        {rdat, cnt, req} = {v, c, 1'b1};
        @(posedge ref_clk) #1;
        req = 0;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    task automatic rdout(logic [23:0] e);
        repeat (2) @(posedge ref_clk);
        rc(8'h07, e[23:16]);
        rc(8'h07, e[15:8]);
        rc(8'h07, e[7:0]);
    endtask
    // cut a hang short
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            end_sim();
        end
    end
    // main sequence
    initial begin
        repeat (10) @(posedge ref_clk);
        #1 rst_n = 1;
        rc(8'hFF, ID);
        rc(8'h08, 8'h0F);
        rc(8'h00, 8'h00);
        rc(8'h0C, 8'h00);
        wr(8'hFF, 8'h00);
        rc(8'hFF, ID);
        foreach (ra[i]) begin
            rv = 8'(rnd());
            wr(ra[i], rv);
            rc(ra[i], (ra[i] == 8'h0F) ? (rv & 8'h07) : rv);
        end
        thr = 8'(rnd()) & 8'h7F;
        d = 24'(rnd()) | 24'h000001;
        wr(8'h02, 8'hF0);
        wr(8'h10, thr);
        wr(8'h15, 8'hA5);
        wr(8'h11, 8'h5C);
        wr(8'h09, d[7:0]);
        wr(8'h0A, d[15:8]);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("slot sources", d[15:0], slots);
        chk("proximity mode", 1, pa);
        chk("pilot drive", 8'hA5, emit);
        push(24'(rnd()), thr);
        chk("proximity mode", 1, pa);
        push(24'(rnd()), thr + 8'h01);
        chk("rate mode", 1, ha);
        chk("emitter drive", 8'h5C, emit);
        chk("irq pin", 1, oe);
        rc(8'h00, 8'h10);
        rc(8'h00, 8'h00);
        wr(8'h02, 8'hE0);
        wr(8'h09, d[7:0]);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("proximity skipped", 2'b01, {pa, ha});
        wr(8'h0D, 8'h04);
        d = 24'(rnd());
        push(d, 0);
        chk("irq pin", 1, oe);
        rc(8'h04, 8'h01);
        rc(8'h00, 8'h40);
        rdout(d);
        d = 24'(rnd());
        push(d, 0);
        rdout(d);
        rc(8'h00, 8'h00);
        thr = 8'(rnd()) & 8'h0F;
        wr(8'h02, 8'h80);
        wr(8'h08, thr);
        wr(8'h04, 8'h00);
        wr(8'h06, 8'h00);
        for (int i = 1; i <= 32; i++) begin
            push(24'(rnd()), 0);
            chk("near full pin", near(i, thr[3:0]), oe);
        end
        repeat (40) push(24'(rnd()), 0);
        rc(8'h05, 8'h1F);
        rc(8'h04, 8'h00);
        rd(8'h07, x);
        chk("near full kept", 1, oe);
        rc(8'h00, 8'h80);
        @(posedge ref_clk) #1;
        chk("near full pin", 0, oe);
        wr(8'h08, 8'h40 | thr);
        wr(8'h04, 8'h00);
        wr(8'h06, 8'h00);
        repeat (32 - thr) push(24'(rnd()), 0);
        chk("near full pin", 1, oe);
        repeat (2) @(posedge ref_clk);
        repeat (3) rd(8'h07, x);
        @(posedge ref_clk) #1;
        chk("near full pin", 0, oe);
        wr(8'h02, 8'h20);
        rd(8'h00, x);
        amb = 1;
        repeat (3) @(posedge ref_clk);
        #1;
        chk("ambient pin", 1, oe);
        rc(8'h00, 8'h20);
        rc(8'h00, 8'h00);
        amb = 0;
        uvl = 1;
        @(posedge ref_clk) #1;
        uvl = 0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk("supply pin", 1, oe);
        rc(8'h00, 8'h01);
        rc(8'h00, 8'h00);
        wr(8'h0D, 8'h06);
        @(posedge ref_clk) #1;
        chk("power down", 2'b10, {pd, ha});
        wr(8'h0D, 8'h01);
        rc(8'h00, 8'h00);
        rc(8'h08, 8'h0F);
        rc(8'h0D, 8'h00);
        chk("power down", 0, pd);
        chk("irq drive level", 0, io);
        end_sim();
    end
endmodule // tb_hrs_regmap
